// *** rtl/pic_cfg.svh ***
// Offsets, field positions, reset values and fixed codes of the interrupt arbiter
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH

// Register indices; byte address is four times the index
`define PIC_IDX_PRIO_A 32'h05ff_ff84
`define PIC_IDX_PRIO_B 32'h05ff_ff86
`define PIC_IDX_PRIO_C 32'h05ff_ff88
`define PIC_IDX_PRIO_D 32'h05ff_ff8a
`define PIC_IDX_PRIO_E 32'h05ff_ff8c
`define PIC_IDX_CTRL 32'h05ff_ff8e

// Reset values
`define PIC_PRIO_RESET 16'h0000
`define PIC_CTRL_RESET 9'h000

// Writable bits
`define PIC_PRIO_WMASK 16'hffff
`define PIC_PRIO_E_WMASK 16'hfff0

// Control register fields
`define PIC_CTRL_PIN_LVL_BIT 15
`define PIC_CTRL_EDGE_SEL_BIT 8

// Fixed levels and vectors
`define PIC_LVL_NMI 5'h10
`define PIC_LVL_BREAK 5'h0f
`define PIC_MASK_AFTER_NMI 4'hf
`define PIC_VEC_NMI 8'h0b
`define PIC_VEC_BREAK 8'h0c
`define PIC_VEC_PIN0 8'h40
`define PIC_VEC_ONCHIP0 8'h48

// Reserved on-chip slots, bit n is vector 72+n
`define PIC_ONCHIP_RSVD 44'hcc0_0888_88aa

// Bus responses
`define PIC_RESP_OKAY 2'h0
`define PIC_RESP_SLVERR 2'h2

`endif

// *** rtl/pic_pkg.sv ***
// Types shared by the interrupt arbiter
package pic_pkg;

    typedef logic [4:0] pic_level_type;

    typedef struct packed {
        logic valid;
        logic [4:0] level;
        logic [3:0] new_mask;
        logic [7:0] vector;
    } pic_cpu_req_type;

endpackage

// *** rtl/pic_arbiter.sv ***
// Prioritizing interrupt arbiter with AXI4-Lite registers
// Contract
// - Levels 0..16 rank requests, 16 highest; maskable level 0 never forwarded.
// - Nonmaskable request is level 16, beats all, ignores cpu mask.
// - Nonmaskable input is edge sensed; edge select bit picks the edge.
// - Accepting the nonmaskable request sets new mask level 15.
// - User break request ranks fixed level 15; mask becomes 15.
// - Each external pin independently uses low level or falling edge.
// - Each external pin has a 4-bit level from the first two registers.
// - Accepted pin or on-chip request loads its programmed level as mask.
// - Eleven on-chip groups of four slots accepted, every source with its own vector.
// - Each on-chip group has one 4-bit level in registers three to five.
// - Sources sharing a field follow a fixed within-module order.
// - Reset sets every pin and module level to 0.
// - Equal levels resolve by default order, lowest vector first.
// - Vectors: 11 nonmaskable, 12 break, 64..71 pins, 72..115 on-chip.
// - Vector times four selects the table entry the cpu reads.
// - Fields sit at bits 15-12, 11-8, 7-4, 3-0 in source order.
// - Request indication pin tells outside logic a source has occurred.
// - Read-only status bit shows the current nonmaskable pin level.
// - Control register reads 0x8000 at reset with pin high, else 0x0000.
// - Decoder compares only index bits 27..24 and 8..0.
// - Forward only when level is strictly above the cpu mask level.
// - Indication pin is released on acceptance, or stays low for higher; the code releases it for a cycle on every acceptance.
// - Edge request latched once until accepted; level request only while low.
// - Edge select 1 rising, 0 falling; sense bit 1 falling, 0 low.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "pic_cfg.svh"

module pic_arbiter #(
    parameter int NUM_PINS = 8,
    parameter int NUM_ONCHIP = 44
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Request sources
    input wire logic nmi_pin,
    input wire logic [NUM_PINS-1:0] external_request_pins_n,
    input wire logic break_unit_req,
    input wire logic [NUM_ONCHIP-1:0] onchip_req,
    // CPU side
    input wire logic [3:0] cpu_mask_level,
    input wire logic cpu_ack,
    output pic_pkg::pic_cpu_req_type cpu_req,
    // Pin to outside logic
    output logic request_indication_out_n
);

    localparam int NUM_SRC = NUM_PINS + NUM_ONCHIP;

    // Field level: register fidx/4, position fidx%4 from the top nibble
    function automatic logic [3:0] field_of(input logic [4:0][15:0] regs,
                                            input logic [4:0] fidx);
        logic [1:0] pos;
        pos = 2'd3 - fidx[1:0];
        return regs[fidx[4:2]][{pos, 2'b00} +: 4];
    endfunction

    // Level of source i, pins first then on-chip slots by group of four
    function automatic pic_pkg::pic_level_type level_of(input logic [4:0][15:0] regs,
                                                        input int i);
        logic [4:0] fidx;
        fidx = (i < NUM_PINS) ? 5'(i) : 5'(NUM_PINS + ((i - NUM_PINS) >> 2));
        return {1'b0, field_of(regs, fidx)};
    endfunction

    function automatic logic [2:0] decode(input logic [31:0] addr);
        logic [31:0] idx;
        idx = {2'b00, addr[31:2]};
        decode = 3'd7;
        if (idx[27:24] == 4'(`PIC_IDX_PRIO_A >> 24)) begin
            case (idx[8:0])
                9'(`PIC_IDX_PRIO_A): decode = 3'd0;
                9'(`PIC_IDX_PRIO_B): decode = 3'd1;
                9'(`PIC_IDX_PRIO_C): decode = 3'd2;
                9'(`PIC_IDX_PRIO_D): decode = 3'd3;
                9'(`PIC_IDX_PRIO_E): decode = 3'd4;
                9'(`PIC_IDX_CTRL): decode = 3'd5;
                default: decode = 3'd7;
            endcase
        end
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [15:0] wmask);
        logic [15:0] nv;
        nv = old;
        if (strb[0]) begin
            nv[7:0] = data[7:0];
        end
        if (strb[1]) begin
            nv[15:8] = data[15:8];
        end
        return nv & wmask;
    endfunction

    // Input synchronisers
    logic nmi_s1_q, nmi_s2_q, nmi_prev_q;
    logic [NUM_PINS-1:0] pin_s1_q, pin_s2_q, pin_prev_q;

    always_ff @(posedge aclk) begin
        // Run through reset: status bit follows pin, no false edge on release
        nmi_s1_q <= nmi_pin;
        nmi_s2_q <= nmi_s1_q;
        nmi_prev_q <= nmi_s2_q;
        if (!aresetn) begin
            pin_s1_q <= '1;
            pin_s2_q <= '1;
            pin_prev_q <= '1;
        end else begin
            pin_s1_q <= external_request_pins_n;
            pin_s2_q <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
        end
    end

    // Registers
    logic [4:0][15:0] prio_q;
    logic nmi_edge_sel_q;
    logic [NUM_PINS-1:0] sense_q;
    logic nmi_latch_q;
    logic [NUM_PINS-1:0] pin_latch_q;
    pic_pkg::pic_cpu_req_type req_q;
    logic ind_n_q;

    // AXI state
    logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
    logic [31:0] awaddr_q, wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;

    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs = s_axi_wvalid & s_axi_wready;
    wire ar_hs = s_axi_arvalid & s_axi_arready;
    wire do_write = aw_got_q & w_got_q;
    wire [2:0] wr_sel = decode(awaddr_q);
    wire [2:0] rd_sel = decode(s_axi_araddr);
    // lowest field of the last register is reserved
    wire [15:0] wr_mask = (wr_sel == 3'd4) ? `PIC_PRIO_E_WMASK : `PIC_PRIO_WMASK;
    // live pin level in bit 15, reset value follows it
    wire [15:0] ctrl_view = {nmi_s2_q, 6'b00_0000, nmi_edge_sel_q, sense_q};
    wire [15:0] rd_word = (rd_sel == 3'd5) ? ctrl_view :
                          (rd_sel < 3'd5) ? prio_q[rd_sel] : 16'h0000;

    assign s_axi_awready = ~aw_got_q & ~bvalid_q;
    assign s_axi_wready = ~w_got_q & ~bvalid_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_hs) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_got_q <= 1'b0;
            end
            if (w_hs) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_got_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= `PIC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wr_sel == 3'd7) ? `PIC_RESP_SLVERR : `PIC_RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `PIC_RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rd_word};
            rresp_q <= (rd_sel == 3'd7) ? `PIC_RESP_SLVERR : `PIC_RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // levels reset to zero; programmable fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prio_q <= {5{`PIC_PRIO_RESET}};
            nmi_edge_sel_q <= 1'b0;
            sense_q <= '0;
        end else if (do_write && wr_sel < 3'd5) begin
            prio_q[wr_sel] <= merge(prio_q[wr_sel], wdata_q, wstrb_q, wr_mask);
        end else if (do_write && wr_sel == 3'd5) begin
            if (wstrb_q[1]) begin
                nmi_edge_sel_q <= wdata_q[`PIC_CTRL_EDGE_SEL_BIT];
            end
            if (wstrb_q[0]) begin
                sense_q <= wdata_q[NUM_PINS-1:0];
            end
        end
    end

    // Acceptance of the presented request
    wire accepted = cpu_ack & req_q.valid;
    wire [7:0] acc_vec = req_q.vector;

    // edge choice for the nonmaskable input
    wire nmi_edge = nmi_edge_sel_q ? (nmi_s2_q & ~nmi_prev_q) : (~nmi_s2_q & nmi_prev_q);
    wire nmi_clr = accepted & (acc_vec == `PIC_VEC_NMI);

    // Pin edges, sense bit NUM_PINS-1 is the first pin
    logic [NUM_PINS-1:0] pin_sense, pin_fall, pin_clr, pin_pend;
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            pin_sense[i] = sense_q[NUM_PINS-1-i];
            pin_fall[i] = pin_prev_q[i] & ~pin_s2_q[i];
            pin_clr[i] = (accepted & (acc_vec == 8'(`PIC_VEC_PIN0 + i))) | ~pin_sense[i];
            // latch in edge mode, live level otherwise
            pin_pend[i] = pin_sense[i] ? pin_latch_q[i] : ~pin_s2_q[i];
        end
    end

    // edge latches, a new edge wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nmi_latch_q <= 1'b0;
            pin_latch_q <= '0;
        end else begin
            nmi_latch_q <= nmi_edge | (nmi_latch_q & ~nmi_clr);
            pin_latch_q <= (pin_fall & pin_sense) | (pin_latch_q & ~pin_clr);
        end
    end

    wire [NUM_SRC-1:0] src_req = {onchip_req & ~`PIC_ONCHIP_RSVD, pin_pend};

    // Winner search
    pic_pkg::pic_level_type best_lvl;
    logic [7:0] best_vec;
    logic forward;
    logic [3:0] new_mask;
    always_comb begin
        // break at fixed 15 with the lowest maskable vector
        best_lvl = break_unit_req ? `PIC_LVL_BREAK : 5'h00;
        best_vec = `PIC_VEC_BREAK;
        // strict compare keeps lower vector on ties
        for (int i = 0; i < NUM_SRC; i++) begin
            if (src_req[i] && level_of(prio_q, i) > best_lvl) begin
                best_lvl = level_of(prio_q, i);
                best_vec = (i < NUM_PINS) ? 8'(`PIC_VEC_PIN0 + i)
                                          : 8'(`PIC_VEC_ONCHIP0 + i - NUM_PINS);
            end
        end
        if (nmi_latch_q) begin
            best_lvl = `PIC_LVL_NMI;
            best_vec = `PIC_VEC_NMI;
        end
        forward = nmi_latch_q | ((best_lvl != 5'h00) & (best_lvl > {1'b0, cpu_mask_level}));
        new_mask = nmi_latch_q ? `PIC_MASK_AFTER_NMI : best_lvl[3:0];
    end

    // request, level and vector held together; dropped on acceptance
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_q <= '0;
            ind_n_q <= 1'b1;
        end else begin
            req_q.valid <= forward & ~accepted;
            req_q.level <= best_lvl;
            req_q.new_mask <= new_mask;
            req_q.vector <= best_vec;
            // low while forwarded, released on acceptance
            ind_n_q <= ~(forward & ~accepted);
        end
    end

    assign cpu_req = req_q;
    assign request_indication_out_n = ind_n_q;

    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_level_zero;
        req_q.valid && req_q.vector >= `PIC_VEC_PIN0 |-> req_q.level != 5'h00;
    endproperty
    a_level_zero: assert property (p_level_zero) else $error("level 0 forwarded");

    property p_nmi_wins;
        nmi_latch_q && !accepted |=> req_q.valid && req_q.vector == `PIC_VEC_NMI;
    endproperty
    a_nmi_wins: assert property (p_nmi_wins) else $error("nonmaskable lost");

    property p_nmi_mask;
        req_q.valid && req_q.vector == `PIC_VEC_NMI |-> req_q.new_mask == 4'hf
            && req_q.level == 5'h10;
    endproperty
    a_nmi_mask: assert property (p_nmi_mask) else $error("nonmaskable mask wrong");

    property p_break_level;
        req_q.valid && req_q.vector == `PIC_VEC_BREAK |-> req_q.level == 5'h0f
            && req_q.new_mask == 4'hf;
    endproperty
    a_break_level: assert property (p_break_level) else $error("break level wrong");

    property p_above_mask;
        req_q.valid && req_q.vector != `PIC_VEC_NMI
            |-> req_q.level > {1'b0, $past(cpu_mask_level)};
    endproperty
    a_above_mask: assert property (p_above_mask) else $error("at or below mask");

    property p_ind_pin;
        (accepted |=> request_indication_out_n)
            and (forward && !accepted |=> !request_indication_out_n);
    endproperty
    a_ind_pin: assert property (p_ind_pin) else $error("indication pin mismatch");

    property p_edge_latch;
        pin_fall[0] && pin_sense[0] |=> pin_latch_q[0];
    endproperty
    a_edge_latch: assert property (p_edge_latch) else $error("edge not latched");

    property p_ack_drop;
        accepted |=> !req_q.valid && (!$past(nmi_clr) || nmi_latch_q == $past(nmi_edge));
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack not honoured");

    property p_write_resp;
        aw_hs && w_hs |-> ##2 s_axi_bvalid;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("no write response");

endmodule
`default_nettype wire

// *** verif/pic_cpu_model.sv ***
// CPU core stand-in that takes arbiter requests and tracks its mask level
`timescale 1ns/1ns
`default_nettype none

module pic_cpu_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Request link
    input wire pic_pkg::pic_cpu_req_type cpu_req,
    output logic cpu_ack,
    output logic [3:0] cpu_mask_level,
    // Bench control
    input wire logic accept_en,
    input wire logic [3:0] ack_delay,
    input wire logic mask_load,
    input wire logic [3:0] mask_value
);
    pic_pkg::pic_cpu_req_type taken_q[$];
    logic [3:0] wait_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            cpu_ack <= 1'b0;
            cpu_mask_level <= 4'h0;
            wait_q <= 4'h0;
        end else begin
            cpu_ack <= 1'b0;
            if (cpu_ack && cpu_req.valid) begin
                taken_q.push_back(cpu_req);
                cpu_mask_level <= cpu_req.new_mask;
            end else if (mask_load) begin
                cpu_mask_level <= mask_value;
            end
            if (cpu_req.valid && accept_en && !cpu_ack) begin
                if (wait_q >= ack_delay) begin
                    cpu_ack <= 1'b1;
                    wait_q <= 4'h0;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end else begin
                wait_q <= 4'h0;
            end
        end
    end
endmodule

`default_nettype wire

// *** verif/pic_arbiter_tb.sv ***
// Self-checking bench for the interrupt arbiter
`timescale 1ns/1ns
`default_nettype none
`include "pic_cfg.svh"

module pic_arbiter_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, cpu_ack, request_indication_out_n;
    logic [1:0] bresp, rresp;
    logic nmi_pin = 1'b1, break_unit_req = 1'b0, accept_en = 1'b1, mask_load = 1'b0;
    logic [7:0] pins_n = 8'hff;
    logic [43:0] onchip_req = '0;
    logic [3:0] cpu_mask_level, ack_delay = 4'h0, mask_value = 4'h0;
    pic_pkg::pic_cpu_req_type cpu_req;
    int err_count = 0;
    int checked = 0;

    always #50 aclk = ~aclk;

    pic_arbiter i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .nmi_pin(nmi_pin),
        .external_request_pins_n(pins_n), .break_unit_req(break_unit_req),
        .onchip_req(onchip_req), .cpu_mask_level(cpu_mask_level), .cpu_ack(cpu_ack),
        .cpu_req(cpu_req), .request_indication_out_n(request_indication_out_n));

    pic_cpu_model i_cpu (.aclk(aclk), .aresetn(aresetn), .cpu_req(cpu_req), .cpu_ack(cpu_ack),
        .cpu_mask_level(cpu_mask_level), .accept_en(accept_en), .ack_delay(ack_delay),
        .mask_load(mask_load), .mask_value(mask_value));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic axi_write(input logic [31:0] idx, input logic [15:0] data, input logic [1:0] resp);
        logic aw_ok, w_ok, b_ok;
        int n;
        n = 0;
        b_ok = 1'b0;
        awaddr <= idx << 2;
        wdata <= {16'h0000, data};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_ok && n < 50) begin
            @(negedge aclk);
            aw_ok = awvalid & awready;
            w_ok = wvalid & wready;
            b_ok = bvalid;
            if (b_ok) check("write response", 32'(resp), 32'(bresp));
            @(posedge aclk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            if (b_ok) bready <= 1'b0;
            n++;
        end
        if (!b_ok) check("write done", 32'h0000_0001, 32'h0000_0000);
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [31:0] idx, input logic [31:0] exp, input logic [1:0] resp,
        input string name);
        logic ar_ok, r_ok;
        int n;
        n = 0;
        r_ok = 1'b0;
        araddr <= idx << 2;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_ok && n < 50) begin
            @(negedge aclk);
            ar_ok = arvalid & arready;
            r_ok = rvalid;
            if (r_ok) check(name, exp, rdata);
            if (r_ok) check("read response", 32'(resp), 32'(rresp));
            @(posedge aclk);
            if (ar_ok) arvalid <= 1'b0;
            if (r_ok) rready <= 1'b0;
            n++;
        end
        if (!r_ok) check("read done", 32'h0000_0001, 32'h0000_0000);
        @(posedge aclk);
    endtask

    task automatic set_mask(input logic [3:0] v);
        mask_value <= v;
        mask_load <= 1'b1;
        @(posedge aclk);
        mask_load <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask

    task automatic quiet(input int n);
        settle(n);
        check("no take", 32'h0000_0000, 32'(i_cpu.taken_q.size()));
        @(posedge aclk);
    endtask

    task automatic wait_take(input logic [7:0] vec, input logic [4:0] lvl, input logic [3:0] mask);
        pic_pkg::pic_cpu_req_type t;
        int n;
        n = 0;
        @(negedge aclk);
        while (i_cpu.taken_q.size() == 0 && n < 40) begin
            @(negedge aclk);
            n++;
        end
        if (i_cpu.taken_q.size() == 0) begin
            check("take seen", 32'h0000_0001, 32'h0000_0000);
        end else begin
            t = i_cpu.taken_q.pop_front();
            check("vector", 32'(vec), 32'(t.vector));
            check("level", 32'(lvl), 32'(t.level));
            check("new mask", 32'(mask), 32'(t.new_mask));
        end
        @(posedge aclk);
    endtask

    task automatic t_regs();
        for (int i = 0; i < 5; i++) begin
            axi_read(`PIC_IDX_PRIO_A + 2 * i, 32'h0000_0000, 2'h0, "level reset");
        end
        axi_read(`PIC_IDX_CTRL, 32'h0000_8000, 2'h0, "control reset");
        for (int i = 0; i < 5; i++) begin
            axi_write(`PIC_IDX_PRIO_A + 2 * i, 16'ha5c3, 2'h0);
            axi_read(`PIC_IDX_PRIO_A + 2 * i, (i == 4) ? 32'h0000_a5c0 : 32'h0000_a5c3, 2'h0,
                "level rw");
        end
        axi_write(`PIC_IDX_CTRL, 16'h7fff, 2'h0);
        axi_read(`PIC_IDX_CTRL, 32'h0000_81ff, 2'h0, "control rw");
        axi_write(`PIC_IDX_PRIO_A ^ 32'h0000_3e00, 16'h1234, 2'h0);
        axi_read(`PIC_IDX_PRIO_A, 32'h0000_1234, 2'h0, "alias");
        axi_read(`PIC_IDX_PRIO_A + 1, 32'h0000_0000, 2'h2, "unmapped");
        axi_write(`PIC_IDX_PRIO_A + 1, 16'hffff, 2'h2);
        $display("test regs done");
    endtask

    task automatic t_pins();
        axi_write(`PIC_IDX_PRIO_B, 16'h0000, 2'h0);
        axi_write(`PIC_IDX_PRIO_A, 16'h5503, 2'h0);
        pins_n <= 8'hf0;
        wait_take(8'h40, 5'h05, 4'h5);
        set_mask(4'h0);
        wait_take(8'h41, 5'h05, 4'h5);
        set_mask(4'h0);
        wait_take(8'h43, 5'h03, 4'h3);
        set_mask(4'h0);
        quiet(12);
        pins_n <= 8'hff;
        $display("test pins done");
    endtask

    task automatic t_level();
        axi_write(`PIC_IDX_CTRL, 16'h0100, 2'h0);
        axi_write(`PIC_IDX_PRIO_B, 16'h7000, 2'h0);
        accept_en <= 1'b0;
        set_mask(4'h7);
        pins_n <= 8'hef;
        settle(8);
        check("valid at mask", 32'h0000_0000, 32'(cpu_req.valid));
        check("indication idle", 32'h0000_0001, 32'(request_indication_out_n));
        @(posedge aclk);
        set_mask(4'h6);
        settle(6);
        check("shown vector", 32'h0000_0044, 32'(cpu_req.vector));
        check("indication low", 32'h0000_0000, 32'(request_indication_out_n));
        @(posedge aclk);
        pins_n <= 8'hff;
        settle(6);
        check("valid released", 32'h0000_0000, 32'(cpu_req.valid));
        @(posedge aclk);
        pins_n <= 8'hef;
        accept_en <= 1'b1;
        wait_take(8'h44, 5'h07, 4'h7);
        settle(2);
        check("indication after take", 32'h0000_0001, 32'(request_indication_out_n));
        @(posedge aclk);
        pins_n <= 8'hff;
        set_mask(4'h0);
        $display("test level done");
    endtask

    task automatic t_nmi();
        axi_write(`PIC_IDX_CTRL, 16'h0000, 2'h0);
        set_mask(4'hf);
        nmi_pin <= 1'b0;
        wait_take(8'h0b, 5'h10, 4'hf);
        axi_read(`PIC_IDX_CTRL, 32'h0000_0000, 2'h0, "pin level low");
        nmi_pin <= 1'b1;
        quiet(10);
        axi_write(`PIC_IDX_CTRL, 16'h0100, 2'h0);
        nmi_pin <= 1'b0;
        quiet(10);
        nmi_pin <= 1'b1;
        wait_take(8'h0b, 5'h10, 4'hf);
        set_mask(4'h0);
        $display("test nmi done");
    endtask

    task automatic t_break();
        set_mask(4'he);
        break_unit_req <= 1'b1;
        wait_take(8'h0c, 5'h0f, 4'hf);
        break_unit_req <= 1'b0;
        set_mask(4'h0);
        $display("test break done");
    endtask

    task automatic t_onchip();
        logic [7:0] exp_vec [4] = '{8'h48, 8'h4a, 8'h50, 8'h51};
        ack_delay <= 4'h3;
        axi_write(`PIC_IDX_PRIO_C, 16'h4040, 2'h0);
        axi_write(`PIC_IDX_PRIO_D, 16'h0000, 2'h0);
        onchip_req <= 44'h000_0001_0307;
        foreach (exp_vec[i]) begin
            wait_take(exp_vec[i], 5'h04, 4'h4);
            onchip_req[exp_vec[i] - 8'h48] <= 1'b0;
            set_mask(4'h0);
        end
        quiet(12);
        onchip_req <= '0;
        ack_delay <= 4'h0;
        $display("test onchip done");
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_pins();
        t_level();
        t_nmi();
        t_break();
        t_onchip();
        conclude();
    end

    // Cuts a hang short well beyond the expected run length
    initial begin
        #(100 * 20000);
        err_count++;
        conclude();
    end
endmodule

`default_nettype wire
